// >>> core/character_video_serializer.sv
// Character cell video serializer: fetches codes, looks up dots, shifts half-dots.
// Assumes a refresh source behind a valid/ready port and a preloaded font memory.
`timescale 1ns/10ps
module character_video_serializer
   import video_serializer_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // Refresh memory words
   input  wire logic [WORD_W-1:0] refresh_data,
   input  wire logic              refresh_valid,
   output logic                   refresh_ready,
   // Mode selection
   input  wire logic              col132_mode,
   input  wire logic              double_wide_a,
   input  wire logic              double_wide_b,
   // Font load port
   input  wire logic              font_we,
   input  wire logic [ROM_AW-1:0] font_addr,
   input  wire logic [ROM_DW-1:0] font_data,
   // Timing outputs
   output logic                   memory_share_phase,
   output logic                   shift_load,
   // Video and character state
   output logic                   video_dot,
   output logic [CODE_W-1:0]      char_code,
   output logic                   cursor_bit,
   output logic [ATTR_W-1:0]      attr_bits,
   // Beam position
   output logic [3:0]             scan_line,
   output logic [4:0]             row_index,
   output logic [7:0]             column_index,
   output logic                   status_row,
   output logic                   underline_zone
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [7:0]        acc_reg, acc_next;
   logic [3:0]        hd_reg, hd_next;
   logic              share_reg, share_next;
   logic              dw_sel_reg, dw_sel_next;
   logic              dw_phase_reg, dw_phase_next;
   logic [3:0]        eff_hd_reg, eff_hd_next;
   logic              load_reg, load_next;
   logic [7:0]        char_len;
   logic [8:0]        acc_sum;
   logic              tick, eff_tick, load_now, char_end;

   stage_state_t      stage_reg, stage_next;
   logic [WORD_W-1:0] stage_word_reg, stage_word_next;
   logic              fifo_valid, fifo_pop, capture;
   logic [WORD_W-1:0] fifo_data;

   logic [WORD_W-1:0] char_word_reg, char_word_next;
   logic [ROM_AW-1:0] rom_addr;
   logic [ROM_DW-1:0] rom_data;

   logic [A_BITS-1:0] a_reg, a_next;
   logic [A_BITS-1:0] b_reg, b_next;
   logic              ext_reg, ext_next;
   logic              video_reg, video_next;

   logic [7:0]        column_reg, column_next;
   logic [3:0]        scan_reg, scan_next;
   logic [4:0]        row_reg, row_next;
   logic [7:0]        col_sum, col_limit;
   logic              status_reg, status_next, under_reg, under_next;

   // ------------------------------------------------------------------
   // Half-dot timing
   // ------------------------------------------------------------------
   // Phase accumulator gives exactly twelve half-dot ticks per character
   // period even though the period is not a multiple of twelve cycles
   always_comb begin
      char_len   = col132_mode ? CHAR_CYCLES_132 : CHAR_CYCLES_80;
      acc_sum    = {1'b0, acc_reg} + {1'b0, HALF_DOTS_PER_CHAR};
      tick       = (acc_sum >= {1'b0, char_len});
      acc_next   = tick ? 8'(acc_sum - {1'b0, char_len}) : acc_sum[7:0];
      hd_next    = hd_reg;
      if (tick) begin
         hd_next = (hd_reg == HALF_DOT_LAST) ? 4'h0 : hd_reg + 4'h1;
      end
      char_end   = tick && (hd_reg == HALF_DOT_LAST);
      // Low in the second half of each character cycle
      share_next = (hd_next < SHARE_LOW_FIRST);
   end

   // Shift clock and load selection between single and double wide sets
   always_comb begin
      eff_tick      = tick && (!dw_sel_reg || dw_phase_reg);
      dw_phase_next = dw_sel_reg ? (tick ? !dw_phase_reg : dw_phase_reg) : 1'b1;
      eff_hd_next   = eff_hd_reg;
      dw_sel_next   = dw_sel_reg;
      if (eff_tick) begin
         eff_hd_next = (eff_hd_reg == HALF_DOT_LAST) ? 4'h0 : eff_hd_reg + 4'h1;
      end
      // Mode only changes at a cell boundary so no cell is cut short
      if (eff_tick && (eff_hd_reg == HALF_DOT_LAST)) begin
         dw_sel_next = double_wide_a | double_wide_b;
      end
      load_now  = eff_tick && (eff_hd_reg == LOAD_HALF_DOT);
      load_next = load_now;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         acc_reg      <= 8'h00;
         hd_reg       <= 4'h0;
         share_reg    <= 1'b1;
         dw_sel_reg   <= 1'b0;
         dw_phase_reg <= 1'b1;
         eff_hd_reg   <= 4'h0;
         load_reg     <= 1'b0;
      end else begin
         acc_reg      <= acc_next;
         hd_reg       <= hd_next;
         share_reg    <= share_next;
         dw_sel_reg   <= dw_sel_next;
         dw_phase_reg <= dw_phase_next;
         eff_hd_reg   <= eff_hd_next;
         load_reg     <= load_next;
      end
   end

   // ------------------------------------------------------------------
   // Refresh word buffering and fetch stage
   // ------------------------------------------------------------------
   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .in_valid  (refresh_valid),
      .in_ready  (refresh_ready),
      .in_data   (refresh_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // The stage sits two characters ahead of the beam; if it is empty at
   // a load the cell shows blank rather than stalling the raster
   always_comb begin
      fifo_pop        = char_end && ((stage_reg == STAGE_EMPTY) || load_now);
      capture         = fifo_pop && fifo_valid;
      stage_next      = stage_reg;
      stage_word_next = stage_word_reg;
      case (stage_reg)
         STAGE_EMPTY: begin
            if (capture) begin
               stage_next      = STAGE_FULL;
               stage_word_next = fifo_data;
            end
         end
         STAGE_FULL: begin
            // A capture in the same cycle as a load keeps the stage full
            if (capture) begin
               stage_word_next = fifo_data;
            end else if (load_now) begin
               stage_next = STAGE_EMPTY;
            end
         end
         default: begin
            stage_next = STAGE_EMPTY;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stage_reg      <= STAGE_EMPTY;
         stage_word_reg <= '0;
      end else begin
         stage_reg      <= stage_next;
         stage_word_reg <= stage_word_next;
      end
   end

   // ------------------------------------------------------------------
   // Character latch and generator lookup
   // ------------------------------------------------------------------
   always_comb begin
      char_word_next = char_word_reg;
      if (load_now) begin
         char_word_next = (stage_reg == STAGE_FULL) ? stage_word_reg : '0;
      end
      rom_addr                = '0;
      rom_addr[CODE_W-1:0]    = char_word_reg[CODE_W-1:0];
      rom_addr[ROM_SCAN_POS0] = scan_reg[0];
      rom_addr[ROM_SCAN_POS1] = scan_reg[1];
      rom_addr[ROM_SCAN_POS2] = scan_reg[2];
      rom_addr[ROM_SCAN_POS3] = scan_reg[3];
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         char_word_reg <= '0;
      end else begin
         char_word_reg <= char_word_next;
      end
   end

   // Lookup settles during the character after the latch
   font_memory #(
      .AW (ROM_AW),
      .DW (ROM_DW)
   ) u_font (
      .sys_clk (sys_clk),
      .wr_en   (font_we),
      .wr_addr (font_addr),
      .wr_data (font_data),
      .rd_addr (rom_addr),
      .rd_data (rom_data)
   );

   // ------------------------------------------------------------------
   // Interleaved shift registers
   // ------------------------------------------------------------------
   // Register A takes even half-dot ticks, B the odd ones, like two
   // shift clocks in antiphase; B leads with a zero so it trails by half
   always_comb begin
      a_next   = a_reg;
      b_next   = b_reg;
      ext_next = ext_reg;
      if (load_now) begin
         a_next   = {rom_data[7], rom_data[5], rom_data[3], rom_data[1]};
         b_next   = {1'b0, rom_data[6], rom_data[4], rom_data[2]};
         ext_next = rom_data[0];
      end else if (eff_tick && !eff_hd_next[0]) begin
         // Refill with the extension bit so columns 4 and 5 repeat rom_data[0]
         a_next = {a_reg[A_BITS-2:0], ext_reg};
      end else if (eff_tick) begin
         b_next = {b_reg[A_BITS-2:0], 1'b0};
      end
      video_next = a_reg[A_BITS-1] | b_reg[A_BITS-1];
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         a_reg     <= '0;
         b_reg     <= '0;
         ext_reg   <= 1'b0;
         video_reg <= 1'b0;
      end else begin
         a_reg     <= a_next;
         b_reg     <= b_next;
         ext_reg   <= ext_next;
         video_reg <= video_next;
      end
   end

   // ------------------------------------------------------------------
   // Beam position counters
   // ------------------------------------------------------------------
   // A double wide character covers two cell positions of the row
   always_comb begin
      col_limit   = col132_mode ? COLS_132 : COLS_80;
      col_sum     = column_reg + (dw_sel_reg ? STEP_DOUBLE : STEP_SINGLE);
      column_next = column_reg;
      scan_next   = scan_reg;
      row_next    = row_reg;
      if (load_now) begin
         column_next = col_sum;
         if (col_sum >= col_limit) begin
            column_next = 8'h00;
            scan_next   = (scan_reg == SCAN_LAST) ? 4'h0 : scan_reg + 4'h1;
            if (scan_reg == SCAN_LAST) begin
               row_next = (row_reg == STATUS_ROW) ? 5'h00 : row_reg + 5'h01;
            end
         end
      end
      // Flags follow the next position so they leave as plain registers
      status_next = (row_next == STATUS_ROW);
      under_next  = (scan_next >= UNDERLINE_SCAN);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         column_reg <= 8'h00;
         scan_reg   <= 4'h0;
         row_reg    <= 5'h00;
         status_reg <= 1'b0;
         under_reg  <= 1'b0;
      end else begin
         column_reg <= column_next;
         scan_reg   <= scan_next;
         row_reg    <= row_next;
         status_reg <= status_next;
         under_reg  <= under_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all straight from registers
   // ------------------------------------------------------------------
   assign memory_share_phase = share_reg;
   assign shift_load         = load_reg;
   assign video_dot          = video_reg;
   assign char_code          = char_word_reg[CODE_W-1:0];
   assign cursor_bit         = char_word_reg[CURSOR_POS];
   assign attr_bits          = char_word_reg[ATTR_LSB +: ATTR_W];
   assign scan_line          = scan_reg;
   assign row_index          = row_reg;
   assign column_index       = column_reg;
   assign status_row         = status_reg;
   assign underline_zone     = under_reg;
endmodule

// >>> common/video_serializer_pkg.sv
// Constants and types shared by the character video serializer and its helpers.
// Assumes a single 250 MHz system clock; all timing counts derive from it.
package video_serializer_pkg;

   // ------------------------------------------------------------------
   // Clock and character timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 4000;
   localparam int PS_PER_NS          = 1000;
   localparam int CHAR_PERIOD_80_NS  = 610;
   localparam int CHAR_PERIOD_132_NS = 410;
   // Longest whole cycle counts; the character period is a ceiling
   localparam logic [7:0] CHAR_CYCLES_80  = 8'(CHAR_PERIOD_80_NS * PS_PER_NS / CLK_PERIOD_PS);
   localparam logic [7:0] CHAR_CYCLES_132 = 8'(CHAR_PERIOD_132_NS * PS_PER_NS / CLK_PERIOD_PS);

   // ------------------------------------------------------------------
   // Cell geometry
   // ------------------------------------------------------------------
   localparam logic [7:0] HALF_DOTS_PER_CHAR = 8'h0C;   // Six dots, two halves each
   localparam logic [3:0] HALF_DOT_LAST      = 4'(HALF_DOTS_PER_CHAR - 8'h01);
   localparam logic [3:0] SHARE_LOW_FIRST    = 4'(HALF_DOTS_PER_CHAR / 8'h02);
   localparam logic [3:0] LOAD_HALF_DOT      = 4'h5;    // Sixth half-dot position
   localparam logic [3:0] SCAN_LAST          = 4'h9;
   localparam logic [3:0] UNDERLINE_SCAN     = 4'h8;
   localparam logic [4:0] STATUS_ROW         = 5'h18;   // Rows 0..23 text, 24 status
   localparam logic [7:0] COLS_80            = 8'h50;
   localparam logic [7:0] COLS_132           = 8'h84;
   localparam logic [7:0] STEP_SINGLE        = 8'h01;
   localparam logic [7:0] STEP_DOUBLE        = 8'h02;

   // ------------------------------------------------------------------
   // Word layout from refresh memory: {attr[3:0], cursor, code[6:0]}
   // ------------------------------------------------------------------
   localparam int CODE_W     = 7;
   localparam int CURSOR_POS = 7;
   localparam int ATTR_LSB   = 8;
   localparam int ATTR_W     = 4;
   localparam int WORD_W     = 12;
   localparam int FIFO_DEPTH = 16;

   // ------------------------------------------------------------------
   // Character generator addressing
   // ------------------------------------------------------------------
   localparam int ROM_AW        = 11;
   localparam int ROM_DW        = 8;
   localparam int ROM_SCAN_POS0 = 7;    // Scan bit one at weight 128
   localparam int ROM_SCAN_POS1 = 9;
   localparam int ROM_SCAN_POS2 = 10;
   localparam int ROM_SCAN_POS3 = 8;    // Scan bit four
   localparam int A_BITS        = 4;

   typedef enum logic {STAGE_EMPTY, STAGE_FULL} stage_state_t;

endpackage

// >>> core/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock; DEPTH must be a power of two.
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
   logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
   logic [PW:0]      count_reg, count_next;
   logic             full_reg, full_next;
   logic             empty_reg, empty_next;
   logic             push, pop;

   // ------------------------------------------------------------------
   // Pointer and flag update
   // ------------------------------------------------------------------
   always_comb begin
      push        = in_valid && !full_reg;
      pop         = out_ready && !empty_reg;
      wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
      full_next   = (count_next == (PW+1)'(DEPTH));
      empty_next  = (count_next == '0);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         full_reg   <= 1'b0;
         empty_reg  <= 1'b1;
         in_ready   <= 1'b1;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         full_reg   <= full_next;
         empty_reg  <= empty_next;
         in_ready   <= !full_next;    // Ready leaves straight from a register
      end
   end

   // Storage needs no reset; flags guard every read
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   assign out_valid = !empty_reg;
   assign out_data  = mem_reg[rd_ptr_reg];
endmodule

// >>> core/font_memory.sv
// Character generator dot memory with a load port and registered read data.
// Assumes the font is written by the surrounding system before display starts.
`timescale 1ns/10ps
module font_memory #(
   parameter int AW = 11,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          sys_clk,
   // Font load port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Lookup port
   input  wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0]      rd_data
);
   logic [DW-1:0] mem_reg [2**AW];

   // ------------------------------------------------------------------
   // Write and registered read
   // ------------------------------------------------------------------
   // A write never forwards to the read port; fonts change off-screen
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
      rd_data <= mem_reg[rd_addr];
   end
endmodule

// >>> verification/video_serializer_assertions.sv
// Port-level checker for the character video serializer.
// Assumes one clock domain and binding to the top module below.
`timescale 1ns/10ps
module video_serializer_assertions
   import video_serializer_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              nrst,
   // Mode inputs
   input wire logic              col132_mode,
   input wire logic              double_wide_a,
   input wire logic              double_wide_b,
   // Timing and latch outputs
   input wire logic              memory_share_phase,
   input wire logic              shift_load,
   input wire logic [CODE_W-1:0] char_code,
   input wire logic              cursor_bit,
   input wire logic [ATTR_W-1:0] attr_bits,
   // Beam position
   input wire logic [3:0]        scan_line,
   input wire logic [4:0]        row_index,
   input wire logic [7:0]        column_index,
   input wire logic              status_row,
   input wire logic              underline_zone
);
   logic [9:0] gap_cnt;
   logic [9:0] period;
   logic [1:0] seen_cnt;
   logic [1:0] mode_reg;
   logic       dw;

   // -----------------------------------------------------------------
   // Load spacing tracker
   // -----------------------------------------------------------------
   // Spacing is judged only from the fourth load after a mode change,
   // because double wide is taken up at a cell boundary
   assign dw     = double_wide_a | double_wide_b;
   // Mode of the previous cycle: a change right after a load must not judge the old gap
   assign period = (mode_reg[1] ? 10'(CHAR_CYCLES_132) : 10'(CHAR_CYCLES_80)) << mode_reg[0];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gap_cnt  <= 10'h000;
         seen_cnt <= 2'h0;
         mode_reg <= 2'h0;
      end else begin
         gap_cnt  <= shift_load ? 10'h001 : gap_cnt + 10'h001;
         mode_reg <= {col132_mode, dw};
         if (mode_reg != {col132_mode, dw})
            seen_cnt <= 2'h0;
         else if (shift_load && seen_cnt != 2'h3)
            seen_cnt <= seen_cnt + 2'h1;
      end
   end

   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence scan_moved;
      !$stable(scan_line);
   endsequence
   sequence latch_moved;
      !$stable({attr_bits, cursor_bit, char_code});
   endsequence

   a_load_period: assert property (
      shift_load && seen_cnt == 2'h3 |-> gap_cnt == period)
      else $error("load pulse spacing differs from the character period");
   a_load_single: assert property (
      shift_load |=> !shift_load [*8])
      else $error("load pulse longer than one cycle");
   a_load_share: assert property (
      shift_load |-> !memory_share_phase)
      else $error("load pulse outside the second half of the character");
   a_share_hold: assert property (
      !$stable(memory_share_phase) |=> $stable(memory_share_phase) [*8])
      else $error("share phase toggles too fast");
   a_latch_load: assert property (
      latch_moved |-> shift_load)
      else $error("character latch changed without a load");
   a_scan_step: assert property (
      scan_moved |-> column_index == 8'h00 && scan_line ==
         ($past(scan_line) == SCAN_LAST ? 4'h0 : $past(scan_line) + 4'h1))
      else $error("scan line step wrong");
   a_status_flag: assert property (
      status_row == (row_index == STATUS_ROW) && row_index <= STATUS_ROW)
      else $error("status row flag wrong");
   a_under_zone: assert property (
      underline_zone == (scan_line >= UNDERLINE_SCAN) && scan_line <= SCAN_LAST)
      else $error("underline zone flag wrong");
endmodule

bind character_video_serializer video_serializer_assertions chk (
   .sys_clk(sys_clk), .nrst(nrst), .col132_mode(col132_mode),
   .double_wide_a(double_wide_a), .double_wide_b(double_wide_b),
   .memory_share_phase(memory_share_phase), .shift_load(shift_load),
   .char_code(char_code), .cursor_bit(cursor_bit), .attr_bits(attr_bits),
   .scan_line(scan_line), .row_index(row_index), .column_index(column_index),
   .status_row(status_row), .underline_zone(underline_zone)
);

// >>> verification/refresh_source_model.sv
// Refresh memory model: offers character words in screen order, stalling at random.
// Assumes the bench hands it a fresh random value every clock.
`timescale 1ns/10ps
module refresh_source_model
   import video_serializer_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // Control from the bench
   input  wire logic              run,
   input  wire logic [15:0]       rnd,
   // Word port
   output logic                   refresh_valid,
   output logic [WORD_W-1:0]      refresh_data,
   input  wire logic              refresh_ready,
   // Accepted word report
   output logic                   taken
);
   assign taken = refresh_valid && refresh_ready;

   // A refused word is held; an idle bus toggles so stale data never looks valid
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         refresh_valid <= 1'b0;
         refresh_data  <= 12'h000;
      end else if (refresh_valid && !refresh_ready) begin
         refresh_valid <= 1'b1;
      end else if (run && rnd[0]) begin
         refresh_valid <= 1'b1;
         refresh_data  <= rnd[15:4];    // One word per cell, screen order
      end else begin
         refresh_valid <= 1'b0;
         refresh_data  <= ~refresh_data;
      end
   end
endmodule

// >>> verification/character_video_serializer_bench.sv
// Bench for the character video serializer: fill, latch order, video, modes, drain.
// Assumes the refresh model beside it and the checker bound to the design.
`timescale 1ns/10ps
module character_video_serializer_bench
   import video_serializer_pkg::*;
;
   logic              sys_clk, nrst, run, font_we, refresh_valid, refresh_ready, taken;
   logic              col132_mode, double_wide_a, double_wide_b, shift_load, video_dot;
   logic              memory_share_phase, cursor_bit, vid_prev, first_load, filled;
   logic [ROM_AW-1:0] font_addr;
   logic [ROM_DW-1:0] font_data;
   logic [WORD_W-1:0] refresh_data;
   logic [CODE_W-1:0] char_code;
   logic [ATTR_W-1:0] attr_bits;
   logic [3:0]        scan_line;
   logic [15:0]       rnd;
   logic [WORD_W-1:0] exp_q[$];
   int                error_cnt, total_checks, rises, accepted;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   character_video_serializer DUT (
      .sys_clk(sys_clk), .nrst(nrst), .refresh_data(refresh_data),
      .refresh_valid(refresh_valid), .refresh_ready(refresh_ready),
      .col132_mode(col132_mode), .double_wide_a(double_wide_a),
      .double_wide_b(double_wide_b), .font_we(font_we), .font_addr(font_addr),
      .font_data(font_data), .memory_share_phase(memory_share_phase),
      .shift_load(shift_load), .video_dot(video_dot), .char_code(char_code),
      .cursor_bit(cursor_bit), .attr_bits(attr_bits), .scan_line(scan_line),
      .row_index(), .column_index(), .status_row(), .underline_zone()
   );

   refresh_source_model partner (
      .sys_clk(sys_clk), .nrst(nrst), .run(run), .rnd(rnd),
      .refresh_valid(refresh_valid), .refresh_data(refresh_data),
      .refresh_ready(refresh_ready), .taken(taken)
   );

   // -----------------------------------------------------------------
   // Clock, random source and watchdog
   // -----------------------------------------------------------------
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) rnd <= lfsr_next(rnd);
   initial begin
      repeat (90000) @(posedge sys_clk);
      error_cnt++;
      finish_test();
   end

   // -----------------------------------------------------------------
   // Scoreboard: accepted words are the expected latch contents
   // -----------------------------------------------------------------
   // The very first load finds the stage empty and shows a blank cell
   always @(posedge sys_clk) begin
      if (shift_load === 1'b1 && first_load)
         first_load = 1'b0;
      else if (shift_load === 1'b1)
         check({attr_bits, cursor_bit, char_code}, exp_q.size() ? exp_q.pop_front() : 0);
      if (!filled && nrst === 1'b1 && refresh_ready === 1'b0) begin
         filled = 1'b1;
         check(accepted, FIFO_DEPTH);
      end
      if (taken === 1'b1) begin
         exp_q.push_back(refresh_data);
         accepted++;
      end
      // Font lights scan line one only; its dots show while scan is 1 or has just stepped to 2
      if (video_dot === 1'b1)
         check(scan_line == 4'h1 || scan_line == 4'h2, 1);
      if (video_dot === 1'b1 && vid_prev !== 1'b1 && (scan_line == 4'h1 || scan_line == 4'h2))
         rises++;
      vid_prev = video_dot;
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      sys_clk       = 1'b0;
      nrst          = 1'b0;
      run           = 1'b0;
      col132_mode   = 1'b0;
      double_wide_a = 1'b0;
      double_wide_b = 1'b0;
      font_we       = 1'b0;
      font_addr     = 11'h000;
      font_data     = 8'h00;
      rnd           = 16'h0028;
      first_load    = 1'b1;
      filled        = 1'b0;
      repeat (2) @(posedge sys_clk);
      check({memory_share_phase, refresh_ready, shift_load, char_code}, 10'h300);
      nrst <= 1'b1;
      run  <= 1'b1;
      // Scan bit one sits at weight 128, so only addresses with bits 10:7 = 0001 light
      for (int a = 0; a < 2048; a++) begin
         font_we   <= 1'b1;
         font_addr <= ROM_AW'(a);
         font_data <= (ROM_AW'(a) >> 7) == 11'h001 ? 8'h80 : 8'h00;
         @(posedge sys_clk);
      end
      font_we <= 1'b0;
      wait (scan_line === 4'h3);
      check(rises, COLS_80);
      // Mode changes: 132 columns, then each double-wide bit alone
      @(posedge sys_clk);
      col132_mode <= 1'b1;
      repeat (6) @(posedge shift_load);
      double_wide_a <= 1'b1;
      repeat (6) @(posedge shift_load);
      double_wide_a <= 1'b0;
      double_wide_b <= 1'b1;
      repeat (6) @(posedge shift_load);
      // Source goes quiet: buffer drains, then blank cells follow
      run <= 1'b0;
      repeat (24) @(posedge shift_load);
      check(exp_q.size(), 0);
      finish_test();
   end
endmodule
